/* File: src/pdcg_top.sv */
// Clock gating control for GPIO ports A to E and the DMA unit.
// Assumes a synchronous register port and peripheral access strobes
// that are synchronous to core_clk_i.
`timescale 1ns/100ps

module pdcg_top
  import pdcg_pkg::*;
#(
  parameter int NUM_UNITS = pdcg_pkg::PDCG_NUM_UNITS
) (
  input  wire logic                 core_clk_i,
  input  wire logic                 resetn_i,
  input  wire logic [31:0]          reg_addr_i,
  input  wire logic [31:0]          reg_wdata_i,
  input  wire logic                 reg_write_i,
  input  wire logic                 reg_read_i,
  output logic      [31:0]          reg_rdata_o,
  input  wire logic                 sleep_i,
  input  wire logic                 deep_sleep_i,
  input  wire logic [NUM_UNITS-1:0] unit_access_i,
  output logic      [NUM_UNITS-1:0] unit_clk_en_o,
  output logic      [NUM_UNITS-1:0] unit_fault_o,
  output pdcg_pkg::pdcg_mode_e      power_mode_o
);
  import pdcg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Gather the unit enables of a gating register: DMA on top, ports below
  function automatic logic [NUM_UNITS-1:0] reg_to_gate(
    input logic [31:0] r
  );
    logic [NUM_UNITS-1:0] g;
    g = '0;
    g[PDCG_PORT_MSB:PDCG_PORT_LSB] = r[PDCG_PORT_MSB:PDCG_PORT_LSB];
    g[NUM_UNITS-1] = r[PDCG_DMA_BIT];
    return g;
  endfunction

  // True when the address hits the given offset inside our base page
  function automatic logic addr_hit(
    input logic [31:0] a,
    input logic [11:0] off
  );
    return (a[31:12] == PDCG_BASE_ADDR[31:12]) && (a[11:0] == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Register file

  logic [31:0] run_port_clock_gate_q;
  logic [31:0] run_port_clock_gate_d;
  logic [31:0] sleep_port_clock_gate_q;
  logic [31:0] sleep_port_clock_gate_d;
  logic [31:0] deep_sleep_port_clock_gate_q;
  logic [31:0] deep_sleep_port_clock_gate_d;
  logic [31:0] run_clock_config_q;
  logic [31:0] run_clock_config_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        hit_run;
  logic        hit_sleep;
  logic        hit_deep;
  logic        hit_cfg;
  logic        auto_clock_gating;

  // Address decode within the system control page
  assign hit_run   = addr_hit(reg_addr_i, PDCG_RUN_GATE_OFF);
  assign hit_sleep = addr_hit(reg_addr_i, PDCG_SLEEP_GATE_OFF);
  assign hit_deep  = addr_hit(reg_addr_i, PDCG_DEEP_GATE_OFF);
  assign hit_cfg   = addr_hit(reg_addr_i, PDCG_RUN_CFG_OFF);
  assign auto_clock_gating = run_clock_config_q[PDCG_AUTO_GATE_BIT];

  // Next register values; reserved bits are masked off on write, so they read as zero
  always_comb begin
    run_port_clock_gate_d        = run_port_clock_gate_q;
    sleep_port_clock_gate_d      = sleep_port_clock_gate_q;
    deep_sleep_port_clock_gate_d = deep_sleep_port_clock_gate_q;
    run_clock_config_d           = run_clock_config_q;
    rdata_d                      = 32'h0000_0000;
    if (reg_write_i) begin
      // Only bit 13 and bits 4:0 of a gating register store, bit 0 of the config register
      if (hit_run) begin
        run_port_clock_gate_d = reg_wdata_i & PDCG_GATE_MASK;
      end
      if (hit_sleep) begin
        sleep_port_clock_gate_d = reg_wdata_i & PDCG_GATE_MASK;
      end
      if (hit_deep) begin
        deep_sleep_port_clock_gate_d = reg_wdata_i & PDCG_GATE_MASK;
      end
      if (hit_cfg) begin
        run_clock_config_d = reg_wdata_i & PDCG_CFG_MASK;
      end
    end
    if (reg_read_i) begin
      // Unmapped addresses read as zero
      case (1'b1)
        hit_run:   rdata_d = run_port_clock_gate_q;
        hit_sleep: rdata_d = sleep_port_clock_gate_q;
        hit_deep:  rdata_d = deep_sleep_port_clock_gate_q;
        hit_cfg:   rdata_d = run_clock_config_q;
        default:   rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Register stage; everything clears so units start unclocked
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      run_port_clock_gate_q        <= PDCG_GATE_RESET;
      sleep_port_clock_gate_q      <= PDCG_GATE_RESET;
      deep_sleep_port_clock_gate_q <= PDCG_GATE_RESET;
      run_clock_config_q           <= PDCG_CFG_RESET;
      rdata_q                      <= 32'h0000_0000;
    end else begin
      run_port_clock_gate_q        <= run_port_clock_gate_d;
      sleep_port_clock_gate_q      <= sleep_port_clock_gate_d;
      deep_sleep_port_clock_gate_q <= deep_sleep_port_clock_gate_d;
      run_clock_config_q           <= run_clock_config_d;
      rdata_q                      <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Mode selection and gate outputs

  pdcg_mode_e           mode_q;
  pdcg_mode_e           mode_d;
  logic [31:0]          sel_gate_reg;
  logic [NUM_UNITS-1:0] sel_gate;
  logic [NUM_UNITS-1:0] gate_q;
  logic [NUM_UNITS-1:0] gate_d;
  logic [NUM_UNITS-1:0] fault_q;
  logic [NUM_UNITS-1:0] fault_d;

  // Deep sleep outranks sleep
  always_comb begin
    if (deep_sleep_i) begin
      mode_d = PDCG_MODE_DEEP;
    end else if (sleep_i) begin
      mode_d = PDCG_MODE_SLEEP;
    end else begin
      mode_d = PDCG_MODE_RUN;
    end
  end

  // Pick the register that governs the present mode
  always_comb begin
    case (mode_q)
      PDCG_MODE_RUN:   sel_gate_reg = run_port_clock_gate_q;
      PDCG_MODE_SLEEP: sel_gate_reg = auto_clock_gating ?
                                      sleep_port_clock_gate_q :
                                      run_port_clock_gate_q;
      PDCG_MODE_DEEP:  sel_gate_reg = auto_clock_gating ?
                                      deep_sleep_port_clock_gate_q :
                                      run_port_clock_gate_q;
      default:         sel_gate_reg = run_port_clock_gate_q;
    endcase
  end

  // Unit enables of the governing register, DMA on top
  assign sel_gate = reg_to_gate(sel_gate_reg);

  // Per-unit clock enable and fault on access to a stopped unit
  for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
    assign gate_d[u]  = sel_gate[u];
    assign fault_d[u] = unit_access_i[u] & ~gate_q[u];
  end

  // Register the gates, faults and mode
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_q  <= PDCG_MODE_RUN;
      gate_q  <= '0;
      fault_q <= '0;
    end else begin
      mode_q  <= mode_d;
      gate_q  <= gate_d;
      fault_q <= fault_d;
    end
  end

  assign unit_clk_en_o = gate_q;
  assign unit_fault_o  = fault_q;
  assign power_mode_o  = mode_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_gate_write(logic hit);
    reg_write_i && hit;
  endsequence

  sequence s_auto_sleep;
    auto_clock_gating && (mode_q == PDCG_MODE_SLEEP);
  endsequence

  sequence s_auto_deep;
    auto_clock_gating && (mode_q == PDCG_MODE_DEEP);
  endsequence

  gate_follow_a: assert property (
    1'b1 |=> gate_q == reg_to_gate($past(sel_gate_reg)))
    else $error("Unit clock enable does not follow selected register");

  fault_gated_a: assert property (
    (|(unit_access_i & ~unit_clk_en_o)) |=>
      (unit_fault_o == $past(unit_access_i & ~unit_clk_en_o)))
    else $error("Access to stopped unit gave no fault");

  no_fault_on_a: assert property (
    ((unit_access_i & ~unit_clk_en_o) == '0) |=> unit_fault_o == '0)
    else $error("Fault raised for clocked or idle unit");

  reset_clear_a: assert property (
    $rose(resetn_i) |-> (run_port_clock_gate_q == PDCG_GATE_RESET) &&
                         (unit_clk_en_o == '0))
    else $error("Gating state not clear after reset");

  read_back_a: assert property (
    (reg_read_i && hit_run) |=> reg_rdata_o == $past(run_port_clock_gate_q))
    else $error("Run gating register read back wrong");

  sleep_select_a: assert property (
    s_auto_sleep |=> gate_q == reg_to_gate($past(sleep_port_clock_gate_q)))
    else $error("Sleep register not used under automatic gating");

  noauto_run_a: assert property (
    !auto_clock_gating |=> gate_q == reg_to_gate($past(run_port_clock_gate_q)))
    else $error("Run register not used without automatic gating");

  write_store_a: assert property (
    s_gate_write(hit_deep) |=>
      deep_sleep_port_clock_gate_q == ($past(reg_wdata_i) & PDCG_GATE_MASK))
    else $error("Deep sleep gating write not stored");

  reserved_zero_a: assert property (
    (reg_read_i && (hit_run || hit_sleep || hit_deep)) |=>
      (reg_rdata_o & ~PDCG_GATE_MASK) == 32'h0000_0000)
    else $error("Reserved gating bits read non-zero");

  base_decode_a: assert property (
    (reg_write_i && (reg_addr_i[31:12] != PDCG_BASE_ADDR[31:12])) |=>
      $stable(run_port_clock_gate_q) && $stable(sleep_port_clock_gate_q))
    else $error("Write outside base page changed a gating register");

  // Run mode always takes the run register
  run_select_a: assert property (
    (mode_q == PDCG_MODE_RUN) |=>
      gate_q == reg_to_gate($past(run_port_clock_gate_q)))
    else $error("Run register not used in run mode");

  deep_select_a: assert property (
    s_auto_deep |=>
      gate_q == reg_to_gate($past(deep_sleep_port_clock_gate_q)))
    else $error("Deep sleep register not used under automatic gating");

  // Mode register follows the inputs one cycle later
  mode_deep_a: assert property (
    deep_sleep_i |=> power_mode_o == PDCG_MODE_DEEP)
    else $error("Deep sleep input did not select deep sleep mode");

  mode_sleep_a: assert property (
    (sleep_i && !deep_sleep_i) |=> power_mode_o == PDCG_MODE_SLEEP)
    else $error("Sleep input did not select sleep mode");

  mode_run_a: assert property (
    (!sleep_i && !deep_sleep_i) |=> power_mode_o == PDCG_MODE_RUN)
    else $error("Idle mode inputs did not select run mode");

  // Port enables land in the low field of a written register
  port_bits_a: assert property (
    s_gate_write(hit_run) |=>
      run_port_clock_gate_q[PDCG_PORT_MSB:PDCG_PORT_LSB] ==
        $past(reg_wdata_i[PDCG_PORT_MSB:PDCG_PORT_LSB]))
    else $error("Port enables not stored from the low field");

  dma_bit_a: assert property (
    s_gate_write(hit_sleep) |=>
      sleep_port_clock_gate_q[PDCG_DMA_BIT] ==
        $past(reg_wdata_i[PDCG_DMA_BIT]))
    else $error("DMA enable not stored from its bit");

  // Read data stand only in the cycle after a read strobe
  rdata_idle_a: assert property (
    !reg_read_i |=> reg_rdata_o == 32'h0000_0000)
    else $error("Read data present without a read strobe");

endmodule

/* File: src/pdcg_pkg.sv */
// Constants for the port and DMA clock gating block.
// Assumes a 32-bit system address and a single 40 MHz system clock.
package pdcg_pkg;

  // Register space base and offsets
  localparam logic [31:0] PDCG_BASE_ADDR        = 32'h400F_E000;
  localparam logic [11:0] PDCG_RUN_GATE_OFF     = 12'h108;
  localparam logic [11:0] PDCG_SLEEP_GATE_OFF   = 12'h118;
  localparam logic [11:0] PDCG_DEEP_GATE_OFF    = 12'h128;
  localparam logic [11:0] PDCG_RUN_CFG_OFF      = 12'h0F0;

  // Field positions
  localparam int          PDCG_DMA_BIT          = 13;
  localparam int          PDCG_PORT_MSB         = 4;
  localparam int          PDCG_PORT_LSB         = 0;
  localparam int          PDCG_AUTO_GATE_BIT    = 0;
  localparam int          PDCG_NUM_UNITS        = 6;

  // Writable bits of a gating register and of the config register
  localparam logic [31:0] PDCG_GATE_MASK        = 32'h0000_201F;
  localparam logic [31:0] PDCG_CFG_MASK         = 32'h0000_0001;

  // Values after reset
  localparam logic [31:0] PDCG_GATE_RESET       = 32'h0000_0000;
  localparam logic [31:0] PDCG_CFG_RESET        = 32'h0000_0000;

  // Power mode, Gray coded along run, sleep, deep sleep
  typedef enum logic [1:0] {
    PDCG_MODE_RUN   = 2'b00,
    PDCG_MODE_SLEEP = 2'b01,
    PDCG_MODE_DEEP  = 2'b11
  } pdcg_mode_e;

endpackage

/* File: test/test_port_dma_clock_gating.sv */
// Self-checking bench for the port and DMA clock gating block.
// Assumes the block is reached at its ports only; the bench drives them.
`timescale 1ns/100ps

module test_port_dma_clock_gating;
  import pdcg_pkg::*;

  logic        core_clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [31:0] reg_addr_i = '0;
  logic [31:0] reg_wdata_i = '0;
  logic        reg_write_i = 1'b0;
  logic        reg_read_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic        sleep_i = 1'b0;
  logic        deep_sleep_i = 1'b0;
  logic [5:0]  unit_access_i = '0;
  logic [5:0]  unit_clk_en_o;
  logic [5:0]  unit_fault_o;
  pdcg_mode_e  power_mode_o;
  int          n_fail = 0;
  int          tests_run = 0;
  logic [11:0] offs [3];
  logic [31:0] vals [3];
  logic [31:0] exps [3];

  pdcg_top i_pdcg_top (
    .core_clk_i    (core_clk_i),
    .resetn_i      (resetn_i),
    .reg_addr_i    (reg_addr_i),
    .reg_wdata_i   (reg_wdata_i),
    .reg_write_i   (reg_write_i),
    .reg_read_i    (reg_read_i),
    .reg_rdata_o   (reg_rdata_o),
    .sleep_i       (sleep_i),
    .deep_sleep_i  (deep_sleep_i),
    .unit_access_i (unit_access_i),
    .unit_clk_en_o (unit_clk_en_o),
    .unit_fault_o  (unit_fault_o),
    .power_mode_o  (power_mode_o)
  );

  // 40 MHz system clock
  always #12.5 core_clk_i = ~core_clk_i;

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] ad(input logic [11:0] o);
    return PDCG_BASE_ADDR + {20'h0_0000, o};
  endfunction

  // Unit order on the ports: ports A to E, then DMA
  function automatic logic [5:0] units(input logic [31:0] r);
    return {r[13], r[4:0]};
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk6(input logic [5:0] got, input logic [5:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk_i);
    reg_write_i <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge core_clk_i);
    reg_write_i <= 1'b0;
  endtask

  // One-cycle read strobe; data stand in the cycle after it
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    @(posedge core_clk_i);
    reg_read_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_read_i <= 1'b0;
    #1;
    chk32(reg_rdata_o, exp);
  endtask

  // Let a register or mode change reach the enables
  task automatic settle();
    repeat (3) @(posedge core_clk_i);
    #1;
  endtask

  // One access cycle, fault pulse checked next cycle and after it
  task automatic access(input logic [5:0] u, input logic [5:0] exp);
    @(posedge core_clk_i);
    unit_access_i <= u;
    @(posedge core_clk_i);
    unit_access_i <= 6'h00;
    #1;
    chk6(unit_fault_o, exp);
    @(posedge core_clk_i);
    #1;
    chk6(unit_fault_o, 6'h00);
  endtask

  task automatic do_reset();
    resetn_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    resetn_i <= 1'b1;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Watchdog against a hang
  initial begin
    #100us;
    n_fail++;
    close_out();
  end

  // Main sequence
  initial begin
    offs = '{PDCG_RUN_GATE_OFF, PDCG_SLEEP_GATE_OFF, PDCG_DEEP_GATE_OFF};
    vals = '{32'hFFFF_FFFF, 32'h0000_2005, 32'hA5A5_500A};
    exps = '{32'h0000_201F, 32'h0000_2005, 32'h0000_000A};
    do_reset();
    for (int i = 0; i < 3; i++) begin
      rd_chk(ad(offs[i]), 32'h0000_0000);
    end
    rd_chk(ad(PDCG_RUN_CFG_OFF), 32'h0000_0000);
    chk6(unit_clk_en_o, 6'h00);
    // Writable fields only, reserved bits read zero
    for (int i = 0; i < 3; i++) begin
      wr(ad(offs[i]), vals[i]);
      rd_chk(ad(offs[i]), exps[i]);
    end
    // Unmapped places ignore writes and read zero
    wr(ad(12'h10C), 32'hFFFF_FFFF);
    rd_chk(ad(12'h10C), 32'h0000_0000);
    wr(32'h400F_F108, 32'h0000_0000);
    rd_chk(32'h400F_F108, 32'h0000_0000);
    rd_chk(ad(PDCG_RUN_GATE_OFF), exps[0]);
    @(posedge core_clk_i);
    #1;
    chk32(reg_rdata_o, 32'h0000_0000);
    // Modes without and with automatic gating
    for (int a = 0; a < 2; a++) begin
      wr(ad(PDCG_RUN_CFG_OFF), {31'h0, a[0]});
      for (int m = 0; m < 3; m++) begin
        @(posedge core_clk_i);
        sleep_i <= (m != 0);
        deep_sleep_i <= (m == 2);
        settle();
        chk6({4'h0, power_mode_o}, {4'h0, m == 2, m != 0});
        chk6(unit_clk_en_o, units(exps[a * m]));
      end
    end
    rd_chk(ad(PDCG_RUN_CFG_OFF), 32'h0000_0001);
    @(posedge core_clk_i);
    sleep_i <= 1'b0;
    deep_sleep_i <= 1'b0;
    // Only port A clocked: all other units fault on access
    wr(ad(PDCG_RUN_GATE_OFF), 32'h0000_0001);
    settle();
    chk6(unit_clk_en_o, 6'h01);
    access(6'h3F, 6'h3E);
    access(6'h01, 6'h00);
    // Second reset in mid-run clears everything
    @(posedge core_clk_i);
    do_reset();
    #1;
    chk6(unit_clk_en_o, 6'h00);
    rd_chk(ad(PDCG_RUN_GATE_OFF), 32'h0000_0000);
    access(6'h20, 6'h20);
    close_out();
  end

endmodule
